// ### src/uafc_serial.sv
// serial port with framing check and hardware address recognition
// Functional notes
// - stop-bit framing check works only in modes 1-3 and only while frame_check_select is set.
// - with the check on, every frame's stop bit is examined and a bad one sets the error flag.
// - the framing error flag holds until software clears it or reset; good frames never clear it.
// - with the check on, the receive done flag rises at the stop bit, not the last data bit.
// - address recognition is active whenever multiproc_enable is set in modes 1-3.
// - with recognition on, only command frames matching given or broadcast set receive done.
// - in 8-bit mode with recognition on, the stop bit is the ninth bit and must be valid.
// - in shift-register mode multiproc_enable has no effect.
// - given address: own address compared only where the mask holds ones.
// - broadcast: own OR mask, compared only where that OR holds ones.
// - reset clears own address and mask, so every address matches.
// - in async modes transmit and receive run independently, full duplex, own dividers loaded with one shared rate.
// - top control bit is the framing error flag if frame_check_select=1, else mode bit zero.
`timescale 1ns/10ps
`include "uafc_consts.svh"
module uafc_serial import uafc_pkg::*; #(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic rx_line,
    output logic tx_line,
    output logic irq
);
    localparam logic [7:0] OVS_LAST = 8'(`UAFC_OVS - 1);
    localparam logic [7:0] OVS_MID = 8'(`UAFC_OVS_MID - 1);

    logic [7:0] sctrl_reg;
    logic frame_err_reg;
    logic frame_check_select_reg;
    logic [7:0] own_reg;
    logic [7:0] mask_reg;
    logic [7:0] rxdata_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;

    logic [DIV_W-1:0] rx_div_reg;
    logic [DIV_W-1:0] tx_div_reg;
    logic [7:0] rdata_reg;

    // register decode
    wire wr_sctrl = reg_write && (reg_addr == `UAFC_OFF_SCTRL);
    wire wr_txdata = reg_write && (reg_addr == `UAFC_OFF_RXDATA);
    wire wr_own = reg_write && (reg_addr == `UAFC_OFF_OWN);
    wire wr_mask = reg_write && (reg_addr == `UAFC_OFF_MASK);
    wire wr_pctrl = reg_write && (reg_addr == `UAFC_OFF_PCTRL);
    wire wr_istat = reg_write && (reg_addr == `UAFC_OFF_IRQ_STAT);
    wire wr_imask = reg_write && (reg_addr == `UAFC_OFF_IRQ_MASK);
    wire wr_div = reg_write && (reg_addr == `UAFC_OFF_DIV);

    wire mode_b0 = sctrl_reg[`UAFC_SC_TOP];
    wire [1:0] mode = {mode_b0, sctrl_reg[`UAFC_SC_MODE1]};
    wire async_mode = (mode != 2'b00);
    wire nine_bit = mode[1];
    wire fc_on = frame_check_select_reg && async_mode;
    wire mp_on = sctrl_reg[`UAFC_SC_MPEN] && async_mode;
    wire rx_en = sctrl_reg[`UAFC_SC_RXEN] && async_mode;
    wire top_bit_rd = frame_check_select_reg ? frame_err_reg : mode_b0;
    wire [7:0] sctrl_rd = {top_bit_rd, sctrl_reg[6:0]};

    // receiver, its own divider
    uafc_state_e rx_state_reg, rx_state_next;
    logic [7:0] rx_ovs_reg;
    logic [3:0] rx_bit_reg;
    logic [8:0] rx_shift_reg;
    logic rx_line_d_reg;
    logic rx_tick;
    // delayed line resets high, so a line held low through reset forms an edge; only the cleared receive enable keeps it from starting
    wire rx_start_edge = (rx_state_reg == UAFC_IDLE) && rx_en && rx_line_d_reg && !rx_line;

    uafc_tick #(.W(DIV_W)) u_rx_tick (
        .clk(clk),
        .reset(reset),
        .restart(rx_start_edge),
        .div_value(rx_div_reg),
        .tick(rx_tick)
    );

    wire [3:0] rx_nbits = nine_bit ? 4'd9 : 4'd8;
    wire rx_ovs_mid = rx_tick && (rx_ovs_reg == OVS_MID);
    wire rx_ovs_end = rx_tick && (rx_ovs_reg == OVS_LAST);
    wire rx_sample = rx_tick && (rx_ovs_reg == OVS_MID) && (rx_state_reg != UAFC_IDLE);
    wire last_data_sample = rx_sample && (rx_state_reg == UAFC_BITS)
                            && (rx_bit_reg == rx_nbits - 4'd1);
    wire stop_sample = rx_sample && (rx_state_reg == UAFC_STOP);
    wire [8:0] shifted = {rx_line, rx_shift_reg[8:1]};
    // assembled data and ninth bit at the moment of the last data sample
    wire [7:0] last_byte = nine_bit ? shifted[7:0] : shifted[8:1];
    wire last_ninth = shifted[8];

    wire [7:0] bcast = own_reg | mask_reg;
    wire given_hit = ((last_byte ^ own_reg) & mask_reg) == 8'h00;
    wire bcast_hit = ((last_byte ^ bcast) & bcast) == 8'h00;
    wire addr_hit = given_hit || bcast_hit;

    // frame verdict held from the last data bit to the stop bit
    logic [7:0] pend_byte_reg;
    logic pend_ninth_reg;
    logic pend_hit_reg;

    // ninth bit zero is data, filtered; command frames must match
    wire nine_ok = !mp_on || (pend_ninth_reg && pend_hit_reg);
    // mode 1 uses the stop bit as the ninth bit
    wire eight_ok = !mp_on || (rx_line && pend_hit_reg);
    wire frame_ok = nine_bit ? nine_ok : eight_ok;
    wire nine_early_ok = !mp_on || (last_ninth && addr_hit);

    // with the check on, completion moves to the stop bit
    wire done_at_last = last_data_sample && nine_bit && !fc_on && nine_early_ok;
    wire done_at_stop = stop_sample && (!nine_bit || fc_on) && frame_ok;
    // a frame ending while done is still set is dropped, data register kept
    wire rx_done_evt = (done_at_last || done_at_stop) && !sctrl_reg[`UAFC_SC_RXDONE];
    wire fe_evt = stop_sample && fc_on && !rx_line;
    // early completion has no held verdict yet, so bits come straight from the shifter
    wire [7:0] done_byte = done_at_last ? last_byte : pend_byte_reg;
    wire done_ninth = done_at_last ? last_ninth : (nine_bit ? pend_ninth_reg : rx_line);

    always_comb begin
        rx_state_next = rx_state_reg;
        case (rx_state_reg)
            UAFC_IDLE: begin
                if (rx_start_edge) rx_state_next = UAFC_START;
            end
            UAFC_START: begin
                if (rx_ovs_mid) rx_state_next = rx_line ? UAFC_IDLE : UAFC_BITS;
            end
            UAFC_BITS: begin
                if (last_data_sample) rx_state_next = UAFC_STOP;
            end
            UAFC_STOP: begin
                if (stop_sample) rx_state_next = UAFC_IDLE;
            end
            default: rx_state_next = UAFC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_state_reg <= UAFC_IDLE;
            rx_ovs_reg <= 8'h00;
            rx_bit_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
            rx_line_d_reg <= 1'b1;
            pend_byte_reg <= 8'h00;
            pend_ninth_reg <= 1'b0;
            pend_hit_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_line_d_reg <= rx_line;
            if (rx_start_edge) begin
                rx_ovs_reg <= 8'h00;
                rx_bit_reg <= 4'h0;
            end else if (rx_ovs_end) begin
                rx_ovs_reg <= 8'h00;
            end else if (rx_tick) begin
                rx_ovs_reg <= rx_ovs_reg + 8'h01;
            end
            if (rx_sample && rx_state_reg == UAFC_BITS) begin
                rx_shift_reg <= shifted;
                rx_bit_reg <= rx_bit_reg + 4'd1;
            end
            if (last_data_sample) begin
                pend_byte_reg <= last_byte;
                pend_ninth_reg <= last_ninth;
                pend_hit_reg <= addr_hit;
            end
        end
    end

    // transmitter, independent divider
    logic [3:0] tx_cnt_reg;
    logic [10:0] tx_shift_reg;
    logic [7:0] tx_ovs_reg;
    logic tx_line_reg;
    logic tx_tick;
    wire tx_busy = (tx_cnt_reg != 4'h0);
    wire tx_go = wr_txdata && !tx_busy && async_mode;
    wire tx_bit_end = tx_tick && (tx_ovs_reg == OVS_LAST) && tx_busy;
    wire [3:0] tx_len = nine_bit ? 4'd11 : 4'd10;
    wire tx_stop_begin = tx_bit_end && (tx_cnt_reg == 4'd2);
    wire tx_done_evt = tx_stop_begin && !sctrl_reg[`UAFC_SC_TXDONE];
    wire [10:0] tx_frame = nine_bit ? {1'b1, sctrl_reg[`UAFC_SC_TX9], reg_wdata, 1'b0}
                                    : {2'b11, reg_wdata, 1'b0};

    // the divider restarts on each new byte so the start bit is never cut short
    uafc_tick #(.W(DIV_W)) u_tx_tick (
        .clk(clk),
        .reset(reset),
        .restart(tx_go),
        .div_value(tx_div_reg),
        .tick(tx_tick)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_cnt_reg <= 4'h0;
            tx_shift_reg <= 11'h7ff;
            tx_ovs_reg <= 8'h00;
            tx_line_reg <= 1'b1;
        end else if (tx_go) begin
            tx_cnt_reg <= tx_len;
            tx_shift_reg <= tx_frame;
            tx_ovs_reg <= 8'h00;
            tx_line_reg <= 1'b0;
        end else if (tx_bit_end) begin
            tx_cnt_reg <= tx_cnt_reg - 4'd1;
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_line_reg <= (tx_cnt_reg == 4'd1) ? 1'b1 : tx_shift_reg[1];
            tx_ovs_reg <= 8'h00;
        end else if (tx_tick && tx_busy) begin
            tx_ovs_reg <= tx_ovs_reg + 8'h01;
        end
    end
    assign tx_line = tx_line_reg;

    // ---- control and status registers; hardware set wins over software write
    // with the check selected the top bit belongs to the error flag, so the mode bit is kept
    wire [7:0] sctrl_wr_val = {frame_check_select_reg ? sctrl_reg[7] : reg_wdata[7],
                               reg_wdata[6:0]};
    always_ff @(posedge clk) begin
        if (reset) begin
            sctrl_reg <= `UAFC_RST_BYTE;
            frame_err_reg <= 1'b0;
            frame_check_select_reg <= 1'b0;
            own_reg <= `UAFC_RST_BYTE;
            mask_reg <= `UAFC_RST_BYTE;
            rxdata_reg <= `UAFC_RST_BYTE;
            irq_mask_reg <= 3'b000;
            rx_div_reg <= DIV_W'(`UAFC_RST_DIV);
            tx_div_reg <= DIV_W'(`UAFC_RST_DIV);
        end else begin
            if (wr_sctrl) sctrl_reg <= sctrl_wr_val;
            if (rx_done_evt) begin
                sctrl_reg[`UAFC_SC_RXDONE] <= 1'b1;
                sctrl_reg[`UAFC_SC_RX9] <= done_ninth;
                rxdata_reg <= done_byte;
            end
            if (tx_done_evt) sctrl_reg[`UAFC_SC_TXDONE] <= 1'b1;

            // only software or reset clears the flag
            if (fe_evt) begin
                frame_err_reg <= 1'b1;
            end else if (wr_sctrl && frame_check_select_reg) begin
                frame_err_reg <= reg_wdata[7];
            end
            if (wr_pctrl) frame_check_select_reg <= reg_wdata[`UAFC_PC_FCSEL];
            if (wr_own) own_reg <= reg_wdata;
            if (wr_mask) mask_reg <= reg_wdata;
            if (wr_imask) irq_mask_reg <= reg_wdata[2:0];
            if (wr_div) begin
                rx_div_reg <= DIV_W'(reg_wdata);
                tx_div_reg <= DIV_W'(reg_wdata);
            end
        end
    end

    // sticky event bits, write one to clear; a new event beats the clear
    wire [2:0] irq_evt = {fe_evt, tx_done_evt, rx_done_evt};
    wire [2:0] irq_clr = wr_istat ? reg_wdata[2:0] : 3'b000;
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_stat_reg <= 3'b000;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // read path, data one cycle after the strobe
    // zero outside the answer cycle, so stale data never looks like a fresh read
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `UAFC_OFF_SCTRL: rd_mux = sctrl_rd;
            `UAFC_OFF_RXDATA: rd_mux = rxdata_reg;
            `UAFC_OFF_OWN: rd_mux = own_reg;
            `UAFC_OFF_MASK: rd_mux = mask_reg;
            `UAFC_OFF_PCTRL: rd_mux = {1'b0, frame_check_select_reg, 6'h00};
            `UAFC_OFF_IRQ_STAT: rd_mux = {5'h00, irq_stat_reg};
            `UAFC_OFF_IRQ_MASK: rd_mux = {5'h00, irq_mask_reg};
            `UAFC_OFF_DIV: rd_mux = rx_div_reg[7:0];
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= reg_read ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_reg;
endmodule : uafc_serial

// ### src/uafc_consts.svh
// register offsets, field positions and reset values of the serial receive block
`ifndef UAFC_CONSTS_SVH
`define UAFC_CONSTS_SVH
`define UAFC_ADDR_W 8
`define UAFC_OFF_SCTRL 8'h98
`define UAFC_OFF_RXDATA 8'h99
`define UAFC_OFF_OWN 8'ha9
`define UAFC_OFF_MASK 8'hb9
`define UAFC_OFF_PCTRL 8'h87
`define UAFC_OFF_IRQ_STAT 8'hc1
`define UAFC_OFF_IRQ_MASK 8'hc2
`define UAFC_OFF_DIV 8'hc3
`define UAFC_SC_TOP 7
`define UAFC_SC_MODE1 6
`define UAFC_SC_MPEN 5
`define UAFC_SC_RXEN 4
`define UAFC_SC_TX9 3
`define UAFC_SC_RX9 2
`define UAFC_SC_TXDONE 1
`define UAFC_SC_RXDONE 0
`define UAFC_PC_FCSEL 6
`define UAFC_IRQ_RX 0
`define UAFC_IRQ_TX 1
`define UAFC_IRQ_FE 2
`define UAFC_RST_BYTE 8'h00
`define UAFC_RST_DIV 16'h001b
`define UAFC_OVS 16
`define UAFC_OVS_MID 8
`endif

// ### src/uafc_pkg.sv
// types shared by the serial receive block
package uafc_pkg;
    typedef enum logic [3:0] {
        UAFC_IDLE = 4'b0001,
        UAFC_START = 4'b0010,
        UAFC_BITS = 4'b0100,
        UAFC_STOP = 4'b1000
    } uafc_state_e;
    typedef logic [1:0] uafc_mode_t;
endpackage : uafc_pkg

// ### src/uafc_tick.sv
// baud tick divider: one pulse every div_value+1 cycles
`timescale 1ns/10ps
module uafc_tick #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic restart,
    input wire logic [W-1:0] div_value,
    output logic tick
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    assign tick = (cnt_reg == div_value);
    assign cnt_next = (restart || tick) ? '0 : cnt_reg + 1'b1;
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : uafc_tick

// ### sim/uafc_serial_chk.sv
// assertion checker for the serial receive block
`timescale 1ns/10ps
module uafc_serial_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic rx_line,
    input wire logic tx_line,
    input wire logic irq
);
    logic [7:0] own_reg, msk_reg;
    logic [2:0] irqm_reg;
    logic fc_reg, m0_reg, mp_reg, fepos_reg, fe_reg, rdst_reg, txu_reg;
    wire wr_st = reg_write && reg_addr == 8'hc1;
    wire wr_ctl = reg_write && reg_addr == 8'h98;
    // shadows of what software wrote; error may only appear once the check was on
    always_ff @(posedge clk) begin
        if (reset) begin
            {own_reg, msk_reg, irqm_reg} <= 19'h00000;
            {fc_reg, m0_reg, mp_reg, fepos_reg, fe_reg, rdst_reg, txu_reg} <= 7'h00;
        end else begin
            if (reg_write && reg_addr == 8'ha9) own_reg <= reg_wdata;
            if (reg_write && reg_addr == 8'hb9) msk_reg <= reg_wdata;
            if (reg_write && reg_addr == 8'hc2) irqm_reg <= reg_wdata[2:0];
            if (reg_write && reg_addr == 8'h87) fc_reg <= reg_wdata[6];
            if (reg_write && reg_addr == 8'h99) txu_reg <= 1'b1;
            if (wr_ctl && !fc_reg) m0_reg <= reg_wdata[7];
            if (wr_ctl) mp_reg <= reg_wdata[5];
            if (fc_reg) fepos_reg <= 1'b1;
            else if (wr_st && reg_wdata[2]) fepos_reg <= 1'b0;
            if (wr_st && reg_wdata[2]) fe_reg <= 1'b0;
            else if (rdst_reg && reg_rdata[2]) fe_reg <= 1'b1;
            rdst_reg <= reg_read && reg_addr == 8'hc1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_rd(logic [7:0] a);
        reg_read && reg_addr == a;
    endsequence
    property p_own_rd; s_rd(8'ha9) |=> reg_rdata == $past(own_reg); endproperty
    property p_msk_rd; s_rd(8'hb9) |=> reg_rdata == $past(msk_reg); endproperty
    property p_irq_off; irqm_reg == 3'b000 |-> !irq; endproperty
    property p_fe_gate; s_rd(8'hc1) ##0 !fepos_reg |=> !reg_rdata[2]; endproperty
    property p_fe_hold; s_rd(8'hc1) ##0 fe_reg |=> reg_rdata[2]; endproperty
    property p_mode_bit; s_rd(8'h98) ##0 !fc_reg |=> reg_rdata[7] == $past(m0_reg); endproperty
    property p_mp_bit; s_rd(8'h98) |=> reg_rdata[5] == $past(mp_reg); endproperty
    property p_tx_idle; !txu_reg |-> tx_line; endproperty
    a_own_rd: assert property (p_own_rd) else $error("own address readback wrong");
    a_msk_rd: assert property (p_msk_rd) else $error("mask readback wrong");
    a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
    a_fe_gate: assert property (p_fe_gate) else $error("frame error without check");
    a_fe_hold: assert property (p_fe_hold) else $error("frame error lost");
    a_mode_bit: assert property (p_mode_bit) else $error("top control bit wrong");
    a_mp_bit: assert property (p_mp_bit) else $error("multiproc bit wrong");
    a_tx_idle: assert property (p_tx_idle) else $error("tx line left idle");
endmodule : uafc_serial_chk

bind uafc_serial uafc_serial_chk u_uafc_serial_chk (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_line(rx_line), .tx_line(tx_line), .irq(irq));

// ### sim/uafc_remote.sv
// remote serial node framing bytes onto the receive line
`timescale 1ns/10ps
module uafc_remote #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    // start bit, lsb first, then a stop level that may be wrong on purpose
    task automatic send(input logic [8:0] data, input int nbits, input logic stop);
        for (int i = 0; i <= nbits + 1; i++) begin
            @(posedge clk);
            line <= (i == 0) ? 1'b0 : (i <= nbits) ? data[i-1] : stop;
            repeat (BIT_CLKS - 1) @(posedge clk);
        end
        @(posedge clk);
        line <= 1'b1;
        repeat (2 * BIT_CLKS) @(posedge clk);
    endtask : send
endmodule : uafc_remote

// ### sim/tb_uafc_serial.sv
// self-checking bench for the serial receive block
`timescale 1ns/10ps
module tb_uafc_serial;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic rx_line, tx_line, irq;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    uafc_serial u_uafc_serial (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
    // divider zero gives 16 clocks per bit
    uafc_remote #(.BIT_CLKS(16)) u_uafc_remote (.clk(clk), .line(rx_line));
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 check($sformatf("reg %h", a), reg_rdata & m, exp);
    endtask : rd
    // read-modify-write of control: done clears, error flag and mode keep their value
    task automatic clr_done;
        logic [7:0] v;
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= 8'h98;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
        wr(8'h98, v & 8'hfe);
    endtask : clr_done
    // one frame, then status (done, error) and data checked, done cleared
    task automatic rx(input logic [8:0] d, input int nb, input logic stop, input logic [7:0] st);
        u_uafc_remote.send(d, nb, stop);
        rd(8'hc1, 8'h05, st);
        if (st[0]) rd(8'h99, 8'hff, d[7:0]);
        wr(8'hc1, 8'h01);
        clr_done();
    endtask : rx
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd(8'ha9, 8'hff, 8'h00);
        rd(8'hb9, 8'hff, 8'h00);
        rd(8'h98, 8'hff, 8'h00);
        rd(8'h00, 8'hff, 8'h00);
        wr(8'hc3, 8'h00);
        $display("test reset values done");
        wr(8'h98, 8'hf0);
        rx(9'h15a, 9, 1'b1, 8'h01);
        wr(8'ha9, 8'h56);
        wr(8'hb9, 8'hfc);
        rx(9'h157, 9, 1'b1, 8'h01);
        rx(9'h166, 9, 1'b1, 8'h00);
        rx(9'h1fe, 9, 1'b1, 8'h01);
        rx(9'h1f0, 9, 1'b1, 8'h00);
        rx(9'h054, 9, 1'b1, 8'h00);
        wr(8'hc2, 8'h01);
        u_uafc_remote.send(9'h1ff, 9, 1'b1);
        #1 check("irq", {7'h00, irq}, 8'h01);
        wr(8'hc2, 8'h00);
        #1 check("irq", {7'h00, irq}, 8'h00);
        wr(8'hc1, 8'h01);
        $display("test address match done");
        wr(8'hb9, 8'hff);
        wr(8'h98, 8'h70);
        rx(9'h056, 8, 1'b1, 8'h01);
        rx(9'h056, 8, 1'b0, 8'h00);
        rx(9'h057, 8, 1'b1, 8'h00);
        $display("test stop as ninth bit done");
        wr(8'h98, 8'h50);
        wr(8'h99, 8'h3c);
        #1 check("tx start", {7'h00, tx_line}, 8'h00);
        rx(9'h0a5, 8, 1'b0, 8'h01);
        rd(8'hc1, 8'h02, 8'h02);
        check("tx idle", {7'h00, tx_line}, 8'h01);
        wr(8'hc1, 8'h02);
        wr(8'h87, 8'h40);
        rx(9'h0a5, 8, 1'b0, 8'h05);
        rx(9'h03c, 8, 1'b1, 8'h05);
        rd(8'h98, 8'h80, 8'h80);
        wr(8'h87, 8'h00);
        wr(8'hc1, 8'h04);
        rd(8'hc1, 8'h04, 8'h00);
        rd(8'h98, 8'h80, 8'h00);
        $display("test framing check done");
        wr(8'h98, 8'h30);
        rx(9'h1ff, 9, 1'b1, 8'h00);
        $display("test shift mode done");
        final_report();
    end
endmodule : tb_uafc_serial
